//--- logic/chan3_status_map.vh
// Address and field map of the channel 3 status and two-way bank block
`ifndef CHAN3_STATUS_MAP_VH
`define CHAN3_STATUS_MAP_VH

// ==========================================================
// Host I/O offsets (5-bit window)
`define HOST_SLOT_BASE   5'h00
`define HOST_DATA_PORT   5'h10
`define HOST_CMD_PORT    5'h14
`define HOST_CD_ADDR_BIT 2

// ==========================================================
// Local processor offsets (5-bit window)
`define LOC_SLOT_BASE    5'h00
`define LOC_INPUT_DATA   5'h10
`define LOC_OUTPUT_DATA  5'h11
`define LOC_STATUS       5'h12

// ==========================================================
// Two-way bank
`define SLOT_FIRST       4'h0
`define SLOT_LAST        4'hf
`define SLOT_FIELD_HI    3
`define SLOT_WINDOW_BIT  4

// ==========================================================
// channel3_twoway_status fields
`define ST_TW_IN_FULL    7
`define ST_TW_OUT_FULL   6
`define ST_HOST_OWNER    5
`define ST_LOCAL_OWNER   4
`define ST_CMD_DATA      3
`define ST_USER_BIT      2
`define ST_IN_FULL       1
`define ST_OUT_FULL      0
`define ST_RESET         8'h00
`define BYTE_ZERO        8'h00

`endif

//--- logic/input_fifo.v
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps

module input_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             sys_clk,
  input  wire             nrst,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  // ==========================================================
  // Storage and pointers
  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr;
  reg  [AW-1:0]    rd_ptr;
  reg  [AW:0]      count;
  wire             push;
  wire             pop;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Depth need not be a power of two, so pointers wrap explicitly
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                  : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                  : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // input_fifo

//--- logic/chan3_status.v
// Channel 3 status flags, two-way bank and data registers
`timescale 1ns/1ps
`include "chan3_status_map.vh"

module chan3_status #(
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW    = 5
) (
  input  wire       sys_clk,
  input  wire       nrst,
  input  wire       twoway_bank_enable,
  input  wire       alt_status_select,
  input  wire       host_wr,
  input  wire       host_rd,
  input  wire [4:0] host_addr,
  input  wire [7:0] host_wdata,
  output reg  [7:0] host_rdata,
  output reg        host_rvalid,
  output reg        host_wr_ready,
  input  wire       local_wr,
  input  wire       local_rd,
  input  wire [4:0] local_addr,
  input  wire [7:0] local_wdata,
  output reg  [7:0] local_rdata,
  output reg        local_rvalid,
  output reg        local_irq,
  output reg  [7:0] channel3_twoway_status
);

  // ==========================================================
  // Flags
  reg        twoway_inbound_full;
  reg        twoway_outbound_full;
  reg        host_write_owner_flag;
  reg        local_write_owner_flag;
  reg        cmd_data_indicator;
  reg        user_general_bit;
  reg        input_full_flag;
  reg        output_full_flag;
  reg  [7:0] output_data_reg;
  reg  [7:0] twoway_bank [0:15];
  reg        next_twoway_inbound_full;
  reg        next_twoway_outbound_full;
  reg        next_host_write_owner_flag;
  reg        next_local_write_owner_flag;
  reg        next_input_full_flag;
  reg        next_output_full_flag;
  reg        next_cmd_data_indicator;
  reg        next_user_general_bit;
  reg  [7:0] next_status;

  // ==========================================================
  // Address decode
  wire       host_slot_hit;
  wire       loc_slot_hit;
  wire [3:0] host_slot;
  wire [3:0] loc_slot;
  wire       h_wr_first;
  wire       h_wr_last;
  wire       h_rd_last;
  wire       h_wr_input;
  wire       h_rd_output;
  wire       l_wr_first;
  wire       l_wr_last;
  wire       l_rd_last;
  wire       l_rd_input;
  wire       l_wr_output;
  wire       l_wr_status;
  wire       layout_on;
  wire       fifo_in_ready;
  wire       fifo_out_valid;
  wire [8:0] fifo_out_data;

  // Bank accesses are ignored while the bank is disabled
  assign host_slot_hit = twoway_bank_enable &
                         !host_addr[`SLOT_WINDOW_BIT];
  assign loc_slot_hit  = twoway_bank_enable &
                         !local_addr[`SLOT_WINDOW_BIT];
  assign host_slot     = host_addr[`SLOT_FIELD_HI:0];
  assign loc_slot      = local_addr[`SLOT_FIELD_HI:0];
  assign h_wr_first    = host_wr & host_slot_hit &
                         (host_slot == `SLOT_FIRST);
  assign h_wr_last     = host_wr & host_slot_hit &
                         (host_slot == `SLOT_LAST);
  assign h_rd_last     = host_rd & host_slot_hit &
                         (host_slot == `SLOT_LAST);
  assign l_wr_first    = local_wr & loc_slot_hit &
                         (loc_slot == `SLOT_FIRST);
  assign l_wr_last     = local_wr & loc_slot_hit &
                         (loc_slot == `SLOT_LAST);
  assign l_rd_last     = local_rd & loc_slot_hit &
                         (loc_slot == `SLOT_LAST);
  // Both data and command ports load the input queue
  assign h_wr_input    = host_wr & fifo_in_ready &
                         ((host_addr == `HOST_DATA_PORT) |
                          (host_addr == `HOST_CMD_PORT));
  assign h_rd_output   = host_rd & (host_addr == `HOST_DATA_PORT);
  assign l_rd_input    = local_rd & (local_addr == `LOC_INPUT_DATA);
  assign l_wr_output   = local_wr & (local_addr == `LOC_OUTPUT_DATA);
  assign l_wr_status   = local_wr & (local_addr == `LOC_STATUS);
  assign layout_on     = twoway_bank_enable | !alt_status_select;

  // ==========================================================
  // Input data queue

  input_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_input_fifo (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .in_valid  (h_wr_input),
    .in_ready  (fifo_in_ready),
    .in_data   ({host_addr[`HOST_CD_ADDR_BIT], host_wdata}),
    .out_valid (fifo_out_valid),
    .out_ready (l_rd_input),
    .out_data  (fifo_out_data)
  );

  // ==========================================================
  // Queue level shadow
  // Ready must already count this cycle's push, or back-to-back host
  // writes would see ready high while the queue has just filled
  reg  [FIFO_AW:0] queue_level;
  reg  [FIFO_AW:0] next_queue_level;
  wire             queue_pop;

  assign queue_pop = l_rd_input & fifo_out_valid;

  always @* begin
    next_queue_level = queue_level;
    if (h_wr_input && !queue_pop) begin
      next_queue_level = queue_level + 1'b1;
    end else if (queue_pop && !h_wr_input) begin
      next_queue_level = queue_level - 1'b1;
    end
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      queue_level <= {(FIFO_AW+1){1'b0}};
    end else begin
      queue_level <= next_queue_level;
    end
  end

  // ==========================================================
  // Flag next-state: every set term wins over a clear term
  always @* begin
    next_twoway_inbound_full = twoway_inbound_full;
    if (l_rd_last) begin
      next_twoway_inbound_full = 1'b0;
    end
    if (h_wr_last) begin
      next_twoway_inbound_full = 1'b1;
    end

    next_twoway_outbound_full = twoway_outbound_full;
    if (h_rd_last) begin
      next_twoway_outbound_full = 1'b0;
    end
    if (l_wr_status && !local_wdata[`ST_TW_OUT_FULL]) begin
      next_twoway_outbound_full = 1'b0;
    end
    if (l_wr_last) begin
      next_twoway_outbound_full = 1'b1;
    end

    next_host_write_owner_flag = host_write_owner_flag;
    if (l_rd_last) begin
      next_host_write_owner_flag = 1'b0;
    end
    if (h_wr_first && !local_write_owner_flag) begin
      next_host_write_owner_flag = 1'b1;
    end

    next_local_write_owner_flag = local_write_owner_flag;
    if (h_rd_last) begin
      next_local_write_owner_flag = 1'b0;
    end
    if (l_wr_status && !local_wdata[`ST_LOCAL_OWNER]) begin
      next_local_write_owner_flag = 1'b0;
    end
    // A host write in the same cycle takes ownership instead
    if (l_wr_first && !host_write_owner_flag && !h_wr_first) begin
      next_local_write_owner_flag = 1'b1;
    end

    next_input_full_flag = input_full_flag;
    if (l_rd_input) begin
      next_input_full_flag = 1'b0;
    end
    if (h_wr_input) begin
      next_input_full_flag = 1'b1;
    end

    next_output_full_flag = output_full_flag;
    if (h_rd_output) begin
      next_output_full_flag = 1'b0;
    end
    if (l_wr_status && !local_wdata[`ST_OUT_FULL]) begin
      next_output_full_flag = 1'b0;
    end
    if (l_wr_output) begin
      next_output_full_flag = 1'b1;
    end

    next_cmd_data_indicator = cmd_data_indicator;
    if (h_wr_input) begin
      next_cmd_data_indicator = host_addr[`HOST_CD_ADDR_BIT];
    end

    // Host has no write path to the user bit
    next_user_general_bit = user_general_bit;
    if (l_wr_status) begin
      next_user_general_bit = local_wdata[`ST_USER_BIT];
    end

    next_status                  = `ST_RESET;
    if (layout_on) begin
      next_status[`ST_TW_IN_FULL]  = next_twoway_inbound_full;
      next_status[`ST_TW_OUT_FULL] = next_twoway_outbound_full;
      next_status[`ST_HOST_OWNER]  = next_host_write_owner_flag;
      next_status[`ST_LOCAL_OWNER] = next_local_write_owner_flag;
      next_status[`ST_CMD_DATA]    = next_cmd_data_indicator;
      next_status[`ST_USER_BIT]    = next_user_general_bit;
      next_status[`ST_IN_FULL]     = next_input_full_flag;
      next_status[`ST_OUT_FULL]    = next_output_full_flag;
    end
  end

  // ==========================================================
  // Flag registers
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      twoway_inbound_full    <= 1'b0;
      twoway_outbound_full   <= 1'b0;
      host_write_owner_flag  <= 1'b0;
      local_write_owner_flag <= 1'b0;
      cmd_data_indicator     <= 1'b0;
      user_general_bit       <= 1'b0;
      input_full_flag        <= 1'b0;
      output_full_flag       <= 1'b0;
      channel3_twoway_status <= `ST_RESET;
      local_irq              <= 1'b0;
      host_wr_ready          <= 1'b0;
    end else begin
      twoway_inbound_full    <= next_twoway_inbound_full;
      twoway_outbound_full   <= next_twoway_outbound_full;
      host_write_owner_flag  <= next_host_write_owner_flag;
      local_write_owner_flag <= next_local_write_owner_flag;
      cmd_data_indicator     <= next_cmd_data_indicator;
      user_general_bit       <= next_user_general_bit;
      input_full_flag        <= next_input_full_flag;
      output_full_flag       <= next_output_full_flag;
      channel3_twoway_status <= next_status;
      local_irq              <= next_twoway_inbound_full |
                                next_input_full_flag;
      // Space left after this edge; a write while low is dropped
      host_wr_ready          <= (next_queue_level !=
                                 FIFO_DEPTH[FIFO_AW:0]);
    end
  end

  // ==========================================================
  // Data storage
  integer i;

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      output_data_reg <= `BYTE_ZERO;
      for (i = 0; i < 16; i = i + 1) begin
        twoway_bank[i] <= `BYTE_ZERO;
      end
    end else begin
      if (l_wr_output) begin
        output_data_reg <= local_wdata;
      end
      // Host wins a same-slot collision, matching the owner priority
      if (local_wr && loc_slot_hit) begin
        twoway_bank[loc_slot] <= local_wdata;
      end
      if (host_wr && host_slot_hit) begin
        twoway_bank[host_slot] <= host_wdata;
      end
    end
  end

  // ==========================================================
  // Read ports: status reads have no side effects
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      host_rdata   <= `BYTE_ZERO;
      host_rvalid  <= 1'b0;
      local_rdata  <= `BYTE_ZERO;
      local_rvalid <= 1'b0;
    end else begin
      host_rvalid  <= host_rd;
      local_rvalid <= local_rd;
      if (host_rd) begin
        if (host_slot_hit) begin
          host_rdata <= twoway_bank[host_slot];
        end else if (host_addr == `HOST_DATA_PORT) begin
          host_rdata <= output_data_reg;
        end else if (host_addr == `HOST_CMD_PORT) begin
          host_rdata <= channel3_twoway_status;
        end else begin
          host_rdata <= `BYTE_ZERO;
        end
      end
      if (local_rd) begin
        if (loc_slot_hit) begin
          local_rdata <= twoway_bank[loc_slot];
        end else if (local_addr == `LOC_INPUT_DATA) begin
          local_rdata <= fifo_out_valid ? fifo_out_data[7:0]
                         : `BYTE_ZERO;
        end else if (local_addr == `LOC_OUTPUT_DATA) begin
          local_rdata <= output_data_reg;
        end else if (local_addr == `LOC_STATUS) begin
          local_rdata <= channel3_twoway_status;
        end else begin
          local_rdata <= `BYTE_ZERO;
        end
      end
    end
  end

endmodule // chan3_status

//--- testbench/chan3_status_monitor.sv
// Port checker for the channel 3 status block
`timescale 1ns/1ps
module chan3_status_monitor (
  input wire       sys_clk,
  input wire       nrst,
  input wire       twoway_bank_enable,
  input wire       alt_status_select,
  input wire       host_wr,
  input wire       host_rd,
  input wire [4:0] host_addr,
  input wire       host_wr_ready,
  input wire       local_wr,
  input wire       local_rd,
  input wire [4:0] local_addr,
  input wire [7:0] local_wdata,
  input wire       local_irq,
  input wire [7:0] channel3_twoway_status
);
  // ==========================================================
  // Decoded events
  wire [7:0] s   = channel3_twoway_status;
  wire       lay = twoway_bank_enable | ~alt_status_select;
  wire       ab2 = host_addr[2];
  wire       ub  = local_wdata[2];
  wire [2:0] kept = {s[6], s[4], s[0]} &
                    {local_wdata[6], local_wdata[4], local_wdata[0]};
  wire       hw0 = host_wr && host_addr == 5'h00 && twoway_bank_enable;
  wire       hwf = host_wr && host_addr == 5'h0f && twoway_bank_enable;
  wire       hrf = host_rd && host_addr == 5'h0f && twoway_bank_enable;
  wire       lw0 = local_wr && local_addr == 5'h00 && twoway_bank_enable;
  wire       lwf = local_wr && local_addr == 5'h0f && twoway_bank_enable;
  wire       lrf = local_rd && local_addr == 5'h0f && twoway_bank_enable;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // Properties
  property p_layout_off;
    !lay ##1 !lay |-> s == 8'h00;
  endproperty
  a_layout_off: assert property (p_layout_off)
    else $error("status visible with layout off");
  property p_tw_in_set;
    hwf && lay ##1 lay |-> s[7] && local_irq;
  endproperty
  a_tw_in_set: assert property (p_tw_in_set)
    else $error("inbound full not set");
  property p_tw_in_clr;
    lrf && !host_wr && lay ##1 lay |-> !s[7] && !s[5];
  endproperty
  a_tw_in_clr: assert property (p_tw_in_clr)
    else $error("inbound full or host owner not cleared");
  property p_tw_out_set;
    lwf && lay ##1 lay |-> s[6];
  endproperty
  a_tw_out_set: assert property (p_tw_out_set)
    else $error("outbound full not set");
  property p_tw_out_clr;
    hrf && !local_wr && lay ##1 lay |-> !s[6] && !s[4];
  endproperty
  a_tw_out_clr: assert property (p_tw_out_clr)
    else $error("outbound full or local owner not cleared");
  property p_host_own;
    hw0 && !s[4] && lay ##1 lay |-> s[5];
  endproperty
  a_host_own: assert property (p_host_own)
    else $error("host owner not set");
  property p_collide;
    hw0 && lw0 && s[5:4] == 2'b00 && lay ##1 lay |-> s[5:4] == 2'b10;
  endproperty
  a_collide: assert property (p_collide)
    else $error("collision not granted to host");
  property p_local_own;
    lw0 && !s[5] && !host_wr && lay ##1 lay |-> s[4];
  endproperty
  a_local_own: assert property (p_local_own)
    else $error("local owner not set");
  property p_cmd;
    host_wr && host_wr_ready && (host_addr == 5'h10 || host_addr == 5'h14)
      && lay ##1 lay |-> s[3] == $past(ab2) && s[1];
  endproperty
  a_cmd: assert property (p_cmd)
    else $error("command bit or input full wrong");
  property p_zero_wr;
    local_wr && local_addr == 5'h12 && !host_rd && lay ##1 lay
      |-> {s[6], s[4], s[0]} == $past(kept) && s[2] == $past(ub);
  endproperty
  a_zero_wr: assert property (p_zero_wr)
    else $error("local status write wrong");
endmodule // chan3_status_monitor

bind chan3_status chan3_status_monitor mon_u (.sys_clk, .nrst,
  .twoway_bank_enable, .alt_status_select, .host_wr, .host_rd, .host_addr,
  .host_wr_ready, .local_wr, .local_rd, .local_addr, .local_wdata,
  .local_irq, .channel3_twoway_status);

//--- testbench/host_model.sv
// Host processor model issuing I/O read and write cycles
`timescale 1ns/1ps
module host_model (
  input  wire        sys_clk,
  output logic       host_wr,
  output logic       host_rd,
  output logic [4:0] host_addr,
  output logic [7:0] host_wdata,
  input  wire  [7:0] host_rdata,
  input  wire        host_rvalid
);
  initial begin
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = 5'h1f;
    host_wdata = 8'h00;
  end
  // Released address and data show the inverse so stale values never look valid
  task automatic io(input bit w, input [4:0] a, input [7:0] d,
                    output [7:0] q);
    int n;
    @(posedge sys_clk);
    #1;
    host_wr = w;
    host_rd = !w;
    host_addr = a;
    host_wdata = d;
    @(posedge sys_clk);
    #1;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = ~a;
    host_wdata = ~d;
    n = 0;
    while (!w && !host_rvalid && n < 8) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    q = host_rdata;
  endtask
endmodule // host_model

//--- testbench/tb_host_channel3_status_flags.sv
// Self-checking bench for the channel 3 status block
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((e) !== (g)) begin \
  mismatches++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_host_channel3_status_flags;
  logic       sys_clk = 1'b0;
  logic       nrst = 1'b0;
  logic       twoway_bank_enable, alt_status_select;
  logic       local_wr, local_rd;
  logic [4:0] local_addr, a;
  logic [7:0] local_wdata, st, q, d;
  wire        host_wr, host_rd, host_rvalid, host_wr_ready;
  wire        local_rvalid, local_irq;
  wire  [4:0] host_addr;
  wire  [7:0] host_wdata, host_rdata, local_rdata, channel3_twoway_status;
  logic [7:0] fq[$];
  int         mismatches = 0;
  int         tests_run = 0;
  always #2.5 sys_clk = ~sys_clk;
  host_model host_u (.sys_clk, .host_wr, .host_rd, .host_addr, .host_wdata,
    .host_rdata, .host_rvalid);
  chan3_status dut_u (.sys_clk, .nrst, .twoway_bank_enable,
    .alt_status_select, .host_wr, .host_rd, .host_addr, .host_wdata,
    .host_rdata, .host_rvalid, .host_wr_ready, .local_wr, .local_rd,
    .local_addr, .local_wdata, .local_rdata, .local_rvalid, .local_irq,
    .channel3_twoway_status);
  // ==========================================================
  // Access tasks and expectations
  task automatic lio(input bit w, input [4:0] ad, input [7:0] dt);
    int n;
    @(posedge sys_clk);
    #1;
    local_wr = w;
    local_rd = !w;
    local_addr = ad;
    local_wdata = dt;
    @(posedge sys_clk);
    #1;
    local_wr = 1'b0;
    local_rd = 1'b0;
    local_wdata = ~dt;
    n = 0;
    while (!w && !local_rvalid && n < 8) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    q = local_rdata;
  endtask
  task hw(input [4:0] ad, input [7:0] dt); host_u.io(1'b1, ad, dt, d); endtask
  task hr(input [4:0] ad); host_u.io(1'b0, ad, 8'h00, q); endtask
  task lw(input [4:0] ad, input [7:0] dt); lio(1'b1, ad, dt); endtask
  task lr(input [4:0] ad); lio(1'b0, ad, 8'h00); endtask
  task cst(input [7:0] e);
    @(posedge sys_clk);
    #1;
    `CHK("status", e, channel3_twoway_status)
  endtask
  function automatic logic [7:0] in_st(input logic [4:0] ad);
    return (st & 8'hf5) | {4'h0, ad[2], 3'b010};
  endfunction
  task test_done;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    local_wr = 1'b0;
    local_rd = 1'b0;
    local_addr = 5'h1f;
    local_wdata = 8'h00;
    twoway_bank_enable = 1'b1;
    alt_status_select = 1'b0;
    d = $urandom(32'h8ed2a497);
    repeat (10) @(posedge sys_clk);
    #1 nrst = 1'b1;
    cst(8'h00);
    hw(5'h00, 8'h3c);
    cst(8'h20);
    hw(5'h0f, 8'hc3);
    cst(8'ha0);
    `CHK("irq", 1'b1, local_irq)
    lr(5'h0f);
    `CHK("slot15", 8'hc3, q)
    cst(8'h00);
    $display("test host bank done");
    lw(5'h00, 8'h11);
    cst(8'h10);
    hw(5'h00, 8'h22);
    cst(8'h10);
    lw(5'h0f, 8'h5a);
    cst(8'h50);
    hr(5'h0f);
    `CHK("slot15", 8'h5a, q)
    cst(8'h00);
    fork
      hw(5'h00, 8'h77);
      lw(5'h00, 8'h88);
    join
    cst(8'h20);
    lr(5'h0f);
    cst(8'h00);
    $display("test local bank done");
    lw(5'h11, 8'h99);
    cst(8'h01);
    lw(5'h00, 8'h00);
    lw(5'h0f, 8'h00);
    lw(5'h12, 8'hff);
    cst(8'h55);
    lw(5'h12, 8'h04);
    cst(8'h04);
    lw(5'h11, 8'he1);
    hr(5'h10);
    `CHK("output", 8'he1, q)
    hr(5'h14);
    `CHK("host status", 8'h04, q)
    lw(5'h12, 8'h00);
    cst(8'h00);
    $display("test status writes done");
    st = 8'h00;
    repeat (32) begin
      a = ($urandom % 2) ? 5'h14 : 5'h10;
      d = $urandom;
      fq.push_back(d);
      hw(a, d);
      st = in_st(a);
      cst(st);
    end
    `CHK("ready", 1'b0, host_wr_ready)
    hw(5'h10, 8'h5e);
    repeat (32) begin
      repeat ($urandom % 3) @(posedge sys_clk);
      lr(5'h10);
      d = fq.pop_front();
      `CHK("input", d, q)
    end
    @(posedge sys_clk);
    #1;
    `CHK("input full", 1'b0, channel3_twoway_status[1])
    `CHK("irq", 1'b0, local_irq)
    $display("test input queue done");
    lw(5'h12, 8'h00);
    hw(5'h0f, 8'h01);
    @(posedge sys_clk);
    #1;
    twoway_bank_enable = 1'b0;
    alt_status_select = 1'b1;
    cst(8'h00);
    alt_status_select = 1'b0;
    st = 8'h80 | (st & 8'h08);
    cst(st);
    lr(5'h12);
    `CHK("local status", st, q)
    $display("test layout done");
    test_done;
  end
  initial begin
    #200000;
    mismatches++;
    test_done;
  end
endmodule // tb_host_channel3_status_flags
